// ### core/spi_status_control_params.svh
`ifndef SPI_STATUS_CONTROL_PARAMS_SVH
`define SPI_STATUS_CONTROL_PARAMS_SVH

// register byte offsets
`define SSC_OFS_STATUS 8'h00
`define SSC_OFS_DATA 8'h04
`define SSC_OFS_CONFIG 8'h08
`define SSC_OFS_IRQ_STAT 8'h0c
`define SSC_OFS_IRQ_MASK 8'h10

// port_status_register fields
`define SSC_BIT_ON 15
`define SSC_BIT_HALT 13
`define SSC_BEC_LSB 8
`define SSC_BIT_SHIFT_EMPTY 7
`define SSC_BIT_OVF 6
`define SSC_BIT_RX_EMPTY 5
`define SSC_SEL_LSB 2
`define SSC_BIT_TXF 1
`define SSC_BIT_RXF 0

// config register fields
`define SSC_BIT_EBE 0
`define SSC_BIT_MASTER 1

// irq status / mask fields
`define SSC_IRQ_BUF 0
`define SSC_IRQ_OVF 1

// reset values
`define SSC_RST_STATUS 16'h0000
`define SSC_RST_CONFIG 2'h0
`define SSC_RST_IRQ 2'h0

// timing
`define SSC_CLK_NS 8
`define SSC_SCK_HALF_NS 32

`endif

// ### core/spi_status_control_pkg.sv
package spi_status_control_pkg;

    typedef enum logic [2:0] {
        SEL_RX_EMPTIED = 3'b000,
        SEL_RX_AVAIL = 3'b001,
        SEL_TX_FULL = 3'b111
    } irq_sel_e;

    typedef enum logic {
        SH_IDLE = 1'b0,
        SH_RUN = 1'b1
    } shift_state_e;

    typedef enum logic [1:0] {
        RESP_OKAY = 2'b00,
        RESP_SLVERR = 2'b10
    } axi_resp_e;

endpackage

// ### core/spi_shifter.sv
`timescale 1ns/1ps
`default_nettype none

module spi_shifter #(
    parameter int WIDTH = 8,
    parameter int HALF = 4
) (
    input wire logic aclk, // clock
    input wire logic aresetn, // sync reset, low
    input wire logic enable, // port on
    input wire logic master, // master mode
    input wire logic tx_valid, // holding word present
    input wire logic [WIDTH-1:0] tx_data, // holding word
    output logic tx_take, // word moved to shifter
    output logic rx_done, // word completed
    output logic [WIDTH-1:0] rx_data, // completed word
    output logic busy, // shifter holds a word
    input wire logic sck_i, // clock pin in
    output logic sck_o, // clock pin out
    output logic sck_oe, // clock pin drive
    output logic sdo, // data out pin
    input wire logic sdi, // data in pin
    input wire logic sel_n // select pin, low
);
    localparam int CNT_W = $clog2(WIDTH);
    localparam int DIV_W = $clog2(HALF) + 1;

    logic sck_s1_q, sck_s2_q, sck_s3_q, sdi_s1_q, sdi_s2_q, sel_s1_q, sel_s2_q;
    spi_status_control_pkg::shift_state_e state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [WIDTH-1:0] sr_q, sr_d, rxw_q, rxw_d;
    logic [DIV_W-1:0] div_q, div_d;
    logic in_bit_q, in_bit_d, sck_q, sck_d, done_q, done_d;
    logic div_hit, rise, fall, sel_act;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {sck_s1_q, sck_s2_q, sck_s3_q} <= 3'h0;
            {sdi_s1_q, sdi_s2_q} <= 2'h0;
            {sel_s1_q, sel_s2_q} <= 2'h3;
        end else begin
            // first stage only feeds the second
            sck_s1_q <= sck_i;
            sck_s2_q <= sck_s1_q;
            sck_s3_q <= sck_s2_q;
            sdi_s1_q <= sdi;
            sdi_s2_q <= sdi_s1_q;
            sel_s1_q <= sel_n;
            sel_s2_q <= sel_s1_q;
        end
    end

    always_comb begin
        div_hit = (state_q == spi_status_control_pkg::SH_RUN) && (div_q == DIV_W'(HALF - 1));
        rise = master ? (div_hit && !sck_q) : (sck_s2_q && !sck_s3_q);
        fall = master ? (div_hit && sck_q) : (!sck_s2_q && sck_s3_q);
        sel_act = !sel_s2_q;
        state_d = state_q;
        cnt_d = cnt_q;
        sr_d = sr_q;
        rxw_d = rxw_q;
        div_d = div_q;
        in_bit_d = in_bit_q;
        sck_d = sck_q;
        done_d = 1'b0;
        tx_take = 1'b0;
        case (state_q)
            spi_status_control_pkg::SH_IDLE: begin
                cnt_d = '0;
                div_d = '0;
                sck_d = 1'b0;
                if (enable && tx_valid && (master || sel_act)) begin
                    sr_d = tx_data;
                    tx_take = 1'b1;
                    state_d = spi_status_control_pkg::SH_RUN;
                end else if (enable && !master && sel_act && rise) begin
                    // slave clocked with nothing queued shifts out zeros
                    sr_d = '0;
                    in_bit_d = sdi_s2_q;
                    state_d = spi_status_control_pkg::SH_RUN;
                end
            end
            spi_status_control_pkg::SH_RUN: begin
                if (master) begin
                    div_d = div_hit ? '0 : div_q + 1'b1;
                    if (div_hit) begin
                        sck_d = !sck_q;
                    end
                end
                if (rise) begin
                    in_bit_d = sdi_s2_q;
                end
                if (fall) begin
                    if (cnt_q == CNT_W'(WIDTH - 1)) begin
                        rxw_d = {sr_q[WIDTH-2:0], in_bit_q};
                        done_d = 1'b1;
                        state_d = spi_status_control_pkg::SH_IDLE;
                    end else begin
                        sr_d = {sr_q[WIDTH-2:0], in_bit_q};
                        cnt_d = cnt_q + 1'b1;
                    end
                end
                // deselect drops a started word; a loaded one waits
                if (!enable || (!master && !sel_act && cnt_q != '0)) begin
                    state_d = spi_status_control_pkg::SH_IDLE;
                end
            end
            default: begin
                state_d = spi_status_control_pkg::SH_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= spi_status_control_pkg::SH_IDLE;
            cnt_q <= '0;
            sr_q <= '0;
            rxw_q <= '0;
            div_q <= '0;
            in_bit_q <= 1'b0;
            sck_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            sr_q <= sr_d;
            rxw_q <= rxw_d;
            div_q <= div_d;
            in_bit_q <= in_bit_d;
            sck_q <= sck_d;
            done_q <= done_d;
        end
    end

    assign rx_done = done_q;
    assign rx_data = rxw_q;
    assign busy = (state_q == spi_status_control_pkg::SH_RUN);
    assign sck_o = sck_q;
    assign sck_oe = enable && master;
    assign sdo = sr_q[WIDTH-1];

endmodule // spi_shifter

`default_nettype wire

// ### core/spi_status_control.sv
// Functional notes
// - count field bits 10-8 shows pending transfers (master) or unread words (slave).
// - enhanced mode: rx empty flag bit 5 high exactly while rx FIFO empty.
// - selector bits 4-2 picks buffer interrupt condition, honoured only in enhanced mode.
// - selector 111 raises interrupt when transmit buffer becomes full.
// - standard mode: tx full bit 1 set on write, cleared on shifter load.
// - enhanced mode: rx full bit 0 set when last location filled.
//
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
`include "spi_status_control_params.svh"
`timescale 1ns/1ps
`default_nettype none

module spi_status_control #(
    parameter int DEPTH = 8,
    parameter int WIDTH = 8
) (
    input wire logic aclk, // clock, 125 MHz
    input wire logic aresetn, // sync reset, low
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [7:0] s_axi_awaddr, // write address
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // byte strobes
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    output logic [1:0] s_axi_bresp, // write response
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    input wire logic [7:0] s_axi_araddr, // read address
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    input wire logic serial_clock_pin_i, // shift clock in
    output logic serial_clock_pin_o, // shift clock out
    output logic serial_clock_pin_oe, // shift clock drive
    output logic serial_out_pin, // serial data out
    input wire logic serial_in_pin, // serial data in
    input wire logic select_pin_n, // slave select, low
    output logic irq // level interrupt
);
    localparam int CW = $clog2(DEPTH + 1);
    localparam int PW = $clog2(DEPTH);
    localparam int HALF_RAW = `SSC_SCK_HALF_NS / `SSC_CLK_NS;
    localparam int SCK_HALF = (HALF_RAW < 1) ? 1 : HALF_RAW;

    // decode shared by read and write paths
    function automatic logic [2:0] reg_index(input logic [7:0] a);
        case (a)
            `SSC_OFS_STATUS: reg_index = 3'h0;
            `SSC_OFS_DATA: reg_index = 3'h1;
            `SSC_OFS_CONFIG: reg_index = 3'h2;
            `SSC_OFS_IRQ_STAT: reg_index = 3'h3;
            `SSC_OFS_IRQ_MASK: reg_index = 3'h4;
            default: reg_index = 3'h7;
        endcase
    endfunction

    logic [WIDTH-1:0] tx_mem [DEPTH];
    logic [WIDTH-1:0] rx_mem [DEPTH];

    logic port_on_q, port_on_d, halt_q, halt_d, ovf_q, ovf_d, ebe_q, ebe_d, master_q, master_d;
    logic [2:0] sel_q, sel_d;
    logic [1:0] irq_stat_q, irq_stat_d, irq_mask_q, irq_mask_d;
    logic [CW-1:0] tx_cnt_q, tx_cnt_d, rx_cnt_q, rx_cnt_d;
    logic [PW-1:0] tx_wp_q, tx_wp_d, tx_rp_q, tx_rp_d, rx_wp_q, rx_wp_d, rx_rp_q, rx_rp_d;
    logic txf_prev_q, rxne_prev_q;
    logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [7:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;

    logic [CW-1:0] cap;
    logic tx_full, rx_full, rx_empty, wr_fire, rd_fire, tx_push, rx_push, rx_pop, buf_evt;
    logic tx_take, rx_done, busy;
    logic [WIDTH-1:0] rx_word;
    logic [2:0] wr_idx, rd_idx, bec;
    logic [15:0] status_word;

    spi_shifter #(
        .WIDTH(WIDTH),
        .HALF(SCK_HALF)
    ) u_shifter (
        .aclk(aclk),
        .aresetn(aresetn),
        .enable(port_on_q),
        .master(master_q),
        .tx_valid(tx_cnt_q != '0),
        .tx_data(tx_mem[tx_rp_q]),
        .tx_take(tx_take),
        .rx_done(rx_done),
        .rx_data(rx_word),
        .busy(busy),
        .sck_i(serial_clock_pin_i),
        .sck_o(serial_clock_pin_o),
        .sck_oe(serial_clock_pin_oe),
        .sdo(serial_out_pin),
        .sdi(serial_in_pin),
        .sel_n(select_pin_n)
    );

    always_comb begin
        // standard mode behaves as a single holding word
        cap = ebe_q ? CW'(DEPTH) : CW'(1);
        tx_full = (tx_cnt_q == cap);
        rx_full = (rx_cnt_q == cap);
        rx_empty = (rx_cnt_q == '0);
        wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
        rd_fire = s_axi_arvalid && s_axi_arready;
        wr_idx = reg_index(awaddr_q);
        rd_idx = reg_index(s_axi_araddr);
        bec = master_q ? tx_cnt_q[2:0] : rx_cnt_q[2:0];
        status_word = `SSC_RST_STATUS;
        status_word[`SSC_BIT_ON] = port_on_q;
        status_word[`SSC_BIT_HALT] = halt_q;
        status_word[`SSC_BEC_LSB +: 3] = bec;
        status_word[`SSC_BIT_SHIFT_EMPTY] = !busy;
        status_word[`SSC_BIT_OVF] = ovf_q;
        status_word[`SSC_BIT_RX_EMPTY] = ebe_q && rx_empty;
        status_word[`SSC_SEL_LSB +: 3] = sel_q;
        status_word[`SSC_BIT_TXF] = tx_full;
        status_word[`SSC_BIT_RXF] = rx_full;
        // writes to a full transmit buffer are dropped
        tx_push = wr_fire && (wr_idx == 3'h1) && wstrb_q[0] && !tx_full && port_on_q;
        rx_push = rx_done && !rx_full;
        rx_pop = rd_fire && (rd_idx == 3'h1) && !rx_empty;
        if (ebe_q) begin
            case (spi_status_control_pkg::irq_sel_e'(sel_q))
                spi_status_control_pkg::SEL_TX_FULL: buf_evt = tx_full && !txf_prev_q;
                spi_status_control_pkg::SEL_RX_AVAIL: buf_evt = !rx_empty && !rxne_prev_q;
                spi_status_control_pkg::SEL_RX_EMPTIED: buf_evt = rx_empty && rxne_prev_q;
                default: buf_evt = 1'b0;
            endcase
        end else begin
            buf_evt = rx_push;
        end

        port_on_d = port_on_q;
        halt_d = halt_q;
        sel_d = sel_q;
        ovf_d = ovf_q;
        ebe_d = ebe_q;
        master_d = master_q;
        irq_mask_d = irq_mask_q;
        irq_stat_d = irq_stat_q;
        if (wr_fire) begin
            case (wr_idx)
                3'h0: begin
                    if (wstrb_q[1]) begin
                        port_on_d = wdata_q[`SSC_BIT_ON];
                        halt_d = wdata_q[`SSC_BIT_HALT];
                    end
                    if (wstrb_q[0]) begin
                        sel_d = wdata_q[`SSC_SEL_LSB +: 3];
                        ovf_d = ovf_q && wdata_q[`SSC_BIT_OVF];
                    end
                end
                3'h2: begin
                    if (wstrb_q[0]) begin
                        ebe_d = wdata_q[`SSC_BIT_EBE];
                        master_d = wdata_q[`SSC_BIT_MASTER];
                    end
                end
                3'h3: begin
                    if (wstrb_q[0]) begin
                        irq_stat_d = irq_stat_q & ~wdata_q[1:0];
                    end
                end
                3'h4: begin
                    if (wstrb_q[0]) begin
                        irq_mask_d = wdata_q[1:0];
                    end
                end
                default: begin
                end
            endcase
        end
        // set wins over a clear in the same cycle
        if (rx_done && rx_full) begin
            ovf_d = 1'b1;
            irq_stat_d[`SSC_IRQ_OVF] = 1'b1;
        end
        if (buf_evt) begin
            irq_stat_d[`SSC_IRQ_BUF] = 1'b1;
        end

        tx_cnt_d = tx_cnt_q + CW'(tx_push) - CW'(tx_take);
        tx_wp_d = tx_push ? tx_wp_q + 1'b1 : tx_wp_q;
        tx_rp_d = tx_take ? tx_rp_q + 1'b1 : tx_rp_q;
        rx_cnt_d = rx_cnt_q + CW'(rx_push) - CW'(rx_pop);
        rx_wp_d = rx_push ? rx_wp_q + 1'b1 : rx_wp_q;
        rx_rp_d = rx_pop ? rx_rp_q + 1'b1 : rx_rp_q;
        // a disabled port or a switch between standard and enhanced mode flushes both buffers
        if (!port_on_q || (ebe_d != ebe_q)) begin
            {tx_cnt_d, rx_cnt_d} = '0;
            {tx_wp_d, tx_rp_d, rx_wp_d, rx_rp_d} = '0;
        end

        aw_hold_d = aw_hold_q || (s_axi_awvalid && s_axi_awready);
        w_hold_d = w_hold_q || (s_axi_wvalid && s_axi_wready);
        awaddr_d = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : awaddr_q;
        wdata_d = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : wdata_q;
        wstrb_d = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb : wstrb_q;
        bvalid_d = bvalid_q && !s_axi_bready;
        bresp_d = bresp_q;
        if (wr_fire) begin
            aw_hold_d = 1'b0;
            w_hold_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = (wr_idx == 3'h7) ? spi_status_control_pkg::RESP_SLVERR : spi_status_control_pkg::RESP_OKAY;
        end
        rvalid_d = rvalid_q && !s_axi_rready;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (rd_fire) begin
            rvalid_d = 1'b1;
            rresp_d = spi_status_control_pkg::RESP_OKAY;
            case (rd_idx)
                3'h0: rdata_d = {16'h0000, status_word};
                3'h1: rdata_d = rx_empty ? 32'h0000_0000 : 32'(rx_mem[rx_rp_q]);
                3'h2: rdata_d = {30'h0000_0000, master_q, ebe_q};
                3'h3: rdata_d = {30'h0000_0000, irq_stat_q};
                3'h4: rdata_d = {30'h0000_0000, irq_mask_q};
                default: begin
                    rdata_d = 32'h0000_0000;
                    rresp_d = spi_status_control_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {port_on_q, halt_q, ovf_q} <= 3'h0;
            sel_q <= 3'h0;
            {master_q, ebe_q} <= `SSC_RST_CONFIG;
            irq_stat_q <= `SSC_RST_IRQ;
            irq_mask_q <= `SSC_RST_IRQ;
            {tx_cnt_q, rx_cnt_q} <= '0;
            {tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q} <= '0;
            {txf_prev_q, rxne_prev_q} <= 2'h0;
            {aw_hold_q, w_hold_q, bvalid_q, rvalid_q} <= 4'h0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            rdata_q <= 32'h0000_0000;
            {bresp_q, rresp_q} <= 4'h0;
        end else begin
            port_on_q <= port_on_d;
            halt_q <= halt_d;
            ovf_q <= ovf_d;
            sel_q <= sel_d;
            ebe_q <= ebe_d;
            master_q <= master_d;
            irq_stat_q <= irq_stat_d;
            irq_mask_q <= irq_mask_d;
            tx_cnt_q <= tx_cnt_d;
            rx_cnt_q <= rx_cnt_d;
            tx_wp_q <= tx_wp_d;
            tx_rp_q <= tx_rp_d;
            rx_wp_q <= rx_wp_d;
            rx_rp_q <= rx_rp_d;
            txf_prev_q <= tx_full;
            rxne_prev_q <= !rx_empty;
            aw_hold_q <= aw_hold_d;
            w_hold_q <= w_hold_d;
            bvalid_q <= bvalid_d;
            rvalid_q <= rvalid_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            rdata_q <= rdata_d;
            bresp_q <= bresp_d;
            rresp_q <= rresp_d;
        end
    end

    // storage needs no reset; counts guard every read
    always_ff @(posedge aclk) begin
        if (tx_push) begin
            tx_mem[tx_wp_q] <= wdata_q[WIDTH-1:0];
        end
        if (rx_push) begin
            rx_mem[rx_wp_q] <= rx_word;
        end
    end

    assign s_axi_awready = !aw_hold_q && !bvalid_q;
    assign s_axi_wready = !w_hold_q && !bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign irq = |(irq_stat_q & irq_mask_q);

endmodule // spi_status_control

`default_nettype wire

// ### verification/spi_status_control_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module spi_status_control_assertions (
    input wire logic aclk, // clock
    input wire logic aresetn, // reset, low
    input wire logic s_axi_awvalid, // aw valid
    input wire logic s_axi_awready, // aw ready
    input wire logic [7:0] s_axi_awaddr, // aw addr
    input wire logic s_axi_wvalid, // w valid
    input wire logic s_axi_wready, // w ready
    input wire logic [31:0] s_axi_wdata, // w data
    input wire logic [3:0] s_axi_wstrb, // w strobes
    input wire logic s_axi_bvalid, // b valid
    input wire logic [1:0] s_axi_bresp, // b resp
    input wire logic s_axi_arvalid, // ar valid
    input wire logic s_axi_arready, // ar ready
    input wire logic [7:0] s_axi_araddr, // ar addr
    input wire logic s_axi_rvalid, // r valid
    input wire logic [31:0] s_axi_rdata, // r data
    input wire logic [1:0] s_axi_rresp, // r resp
    input wire logic serial_clock_pin_o, // sck out
    input wire logic serial_clock_pin_oe, // sck drive
    input wire logic serial_out_pin, // sdo
    input wire logic irq // interrupt
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [7:0] wa_q, ra_q;
    logic [31:0] wd_q;
    logic [3:0] ws_q;
    logic [1:0] cfg_q, mask_q;
    logic on_q, bv_q;
    wire logic st_rd = s_axi_rvalid && ra_q == 8'h00 && s_axi_rresp == 2'b00;
    wire logic oe_exp = on_q && cfg_q[1];
    // shadows trail the registers by one cycle
    always_ff @(posedge aclk) begin
        bv_q <= s_axi_bvalid;
        if (s_axi_awvalid && s_axi_awready) wa_q <= s_axi_awaddr;
        if (s_axi_wvalid && s_axi_wready) {wd_q, ws_q} <= {s_axi_wdata, s_axi_wstrb};
        if (s_axi_arvalid && s_axi_arready) ra_q <= s_axi_araddr;
        if (!aresetn) begin
            {cfg_q, mask_q, on_q} <= 5'h00;
        end else if (s_axi_bvalid && !bv_q && s_axi_bresp == 2'b00) begin
            if (wa_q == 8'h08) cfg_q <= wd_q[1:0];
            if (wa_q == 8'h10) mask_q <= wd_q[1:0];
            if (wa_q == 8'h00 && ws_q[1]) on_q <= wd_q[15];
        end
    end
    AST_RXF_NOT_EMPTY: assert property (st_rd && s_axi_rdata[0] |-> !s_axi_rdata[5])
        else $error("rx full and empty");
    AST_RXE_STD: assert property (st_rd && !cfg_q[0] |-> !s_axi_rdata[5])
        else $error("rx empty outside enhanced");
    AST_EMPTY_CNT: assert property (st_rd && cfg_q == 2'b01 && s_axi_rdata[5] |-> s_axi_rdata[10:8] == 3'h0)
        else $error("count nonzero while empty");
    AST_RSVD_ZERO: assert property (st_rd |-> s_axi_rdata[31:16] == 16'h0 && !s_axi_rdata[14]
        && s_axi_rdata[12:11] == 2'h0)
        else $error("unused bits set");
    AST_STD_TXF: assert property (st_rd && cfg_q == 2'b10 |-> s_axi_rdata[1] == (s_axi_rdata[10:8] == 3'h1))
        else $error("tx full vs pending count");
    AST_IRQ_MASKED: assert property ((mask_q == 2'h0) [*3] |-> !$past(irq))
        else $error("irq while masked");
    AST_SCK_OE: assert property ($stable(oe_exp) |-> $past(serial_clock_pin_oe) == oe_exp)
        else $error("clock drive mismatch");
    AST_SCK_HALF: assert property ($rose(serial_clock_pin_o) |-> serial_clock_pin_o [*4] ##1 !serial_clock_pin_o)
        else $error("clock high phase length");
    AST_SDO_HOLD: assert property ($rose(serial_clock_pin_o) |-> $stable(serial_out_pin) [*4])
        else $error("data out moved");
    cover property (st_rd && s_axi_rdata[0]);
    cover property ($rose(irq));
    cover property ($rose(serial_clock_pin_o));
endmodule // spi_status_control_assertions
bind spi_status_control spi_status_control_assertions chk_u (.*);
`default_nettype wire

// ### verification/spi_peer_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_peer_model (
    input wire logic dut_sck, // clock from block
    input wire logic dut_oe, // block drives clock
    input wire logic sdo, // data from block
    output logic sdi, // data to block
    output logic sck, // own clock, frames only
    output logic sel_n, // select, low
    output logic [7:0] rx_byte // last word seen
);
    logic [7:0] tx_q, rx_sr, nxt;
    logic [2:0] n_q;
    wire logic sck_w = dut_oe ? dut_sck : sck;
    // released line inverted, hides a stale bit
    assign sdi = (dut_oe || !sel_n) ? tx_q[7] : ~tx_q[7];
    initial {sck, sel_n, tx_q, nxt, rx_sr, rx_byte, n_q} = 37'h8_0000_0000;
    always @(posedge sck_w) begin
        rx_sr = {rx_sr[6:0], sdo};
        if (n_q == 3'h7) rx_byte = rx_sr;
        n_q = n_q + 3'h1;
    end
    always @(negedge sck_w) begin
        tx_q = (n_q == 3'h0) ? nxt : {tx_q[6:0], 1'b0};
    end
    task automatic frame(input logic [7:0] b);
        tx_q = b;
        nxt = b;
        #3 sel_n = 1'b0;
        #64;
        repeat (8) begin
            sck = 1'b1;
            #32 sck = 1'b0;
            #32;
        end
        sel_n = 1'b1;
        #64;
    endtask
endmodule // spi_peer_model
`default_nettype wire

// ### verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, serial_clock_pin_o, serial_clock_pin_oe;
    logic serial_out_pin, serial_in_pin, select_pin_n, sck, irq;
    logic [7:0] s_axi_awaddr, s_axi_araddr, prx, b1, b2, p1, p2;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [7:0] tq [8], rq [8];
    integer seed = 32'h0a178d1c;
    integer failures = 0;
    integer n_checks = 0;
    spi_status_control dut_u (.*, .serial_clock_pin_i(sck));
    spi_peer_model peer_u (.dut_sck(serial_clock_pin_o), .dut_oe(serial_clock_pin_oe), .sdo(serial_out_pin),
        .sdi(serial_in_pin), .sck(sck), .sel_n(select_pin_n), .rx_byte(prx));
    initial aclk = 1'b0;
    always #4 aclk = ~aclk;
    task automatic end_of_test;
        if (failures == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    function automatic logic [31:0] st(input logic on, input logic [2:0] c, input logic ov, input logic re,
        input logic [2:0] sel, input logic tf, input logic rf);
        return {16'h0, on, 4'h0, c, 1'b0, ov, re, sel, tf, rf};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge aclk);
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        s_axi_araddr <= a;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // bit 7 masked: idle level varies
    task automatic chk_st(input logic [31:0] e);
        rd_reg(8'h00);
        chk("status", e, rd & 32'hff7f);
    endtask
    task automatic chk_irq(input logic e);
        repeat (2) @(negedge aclk);
        chk("irq", {31'h0, e}, {31'h0, irq});
    endtask
    task automatic poll(input logic [31:0] m, input logic [31:0] v);
        for (int i = 0; i < 400; i++) begin
            rd_reg(8'h00);
            if ((rd & m) === v) break;
        end
        chk("poll", v, rd & m);
    endtask
    initial begin
        repeat (40000) @(posedge aclk);
        failures++;
        end_of_test;
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hf;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        chk_st(st(0, 3'h0, 0, 0, 3'h0, 0, 0));
        wr(8'h14, 32'h0);
        chk("bresp", 32'h2, {30'h0, rs});
        rd_reg(8'h14);
        chk("rresp", 32'h2, {30'h0, rs});
        chk("rdata", 32'h0, rd);
        {b1, b2, p1, p2} = 32'($random(seed));
        peer_u.tx_q = p1;
        peer_u.nxt = p2;
        wr(8'h08, 32'h2);
        wr(8'h00, 32'h8000);
        wr(8'h04, {24'h0, b1});
        wr(8'h04, {24'h0, b2});
        chk_st(st(1, 3'h1, 0, 0, 3'h0, 1, 0));
        poll(32'h0780, 32'h0080);
        chk("peer word", {24'h0, b2}, {24'h0, prx});
        chk_st(st(1, 3'h0, 1, 0, 3'h0, 0, 1));
        chk_irq(0);
        rd_reg(8'h04);
        chk("rx word", {24'h0, p1}, rd);
        chk_st(st(1, 3'h0, 1, 0, 3'h0, 0, 0));
        wr(8'h10, 32'h2);
        chk_irq(1);
        wr(8'h0c, 32'h3);
        chk_irq(0);
        wr(8'h00, 32'h8000);
        chk_st(st(1, 3'h0, 0, 0, 3'h0, 0, 0));
        wr(8'h08, 32'h1);
        wr(8'h00, 32'h801c);
        wr(8'h10, 32'h1);
        for (int i = 0; i < 8; i++) begin
            tq[i] = 8'($random(seed));
            wr(8'h04, {24'h0, tq[i]});
            if (i == 6) chk_irq(0);
        end
        chk_st(st(1, 3'h0, 0, 1, 3'h7, 1, 0));
        chk_irq(1);
        wr(8'h0c, 32'h1);
        chk_irq(0);
        wr(8'h00, 32'h8004);
        for (int k = 1; k <= 8; k++) begin
            rq[k-1] = 8'($random(seed));
            peer_u.frame(rq[k-1]);
            chk("peer word", {24'h0, tq[k-1]}, {24'h0, prx});
            if (k < 8) poll(32'h0700, 32'(k) << 8);
            else poll(32'h1, 32'h1);
            if (k == 1) chk_irq(1);
        end
        chk_st(st(1, 3'h0, 0, 0, 3'h1, 0, 1));
        peer_u.frame(8'($random(seed)));
        poll(32'h0040, 32'h0040);
        for (int k = 0; k < 8; k++) begin
            rd_reg(8'h04);
            chk("rx word", {24'h0, rq[k]}, rd);
            rd_reg(8'h00);
            chk("rx full", 32'h0, rd & 32'h1);
        end
        chk_st(st(1, 3'h0, 1, 1, 3'h1, 0, 0));
        end_of_test;
    end
endmodule // tb
`default_nettype wire
